// ### ucr_pkg.sv
// Constants and types shared by the universal control register block
// What this block does
// (R1) Framing bypass bit skips MPEG sync search
// (R2) Host keeps factory fields at fixed values
// (R3) Two-bit field selects error correction standard
// (R4) Test bypass routes data around the demodulator
// (R5) Receive load strobes push M/N to synthesizer
// (R6) Transmit load strobes push M/N to synthesizer
// (R7) Start bit launches an acquisition attempt
// (R8) Failure declared when attempts reach retry limit
// (R9) Acquisition restarts after a declared failure
// (R10) Host sets demodulator enable before start
// (R11) Two-bit field selects 16/64/256 point constellation
// (R12) FIFO reset bit clears the output FIFO
// (R13) Receive bypass bit bypasses receive synthesizer
// (R14) Transmit bypass bit bypasses transmit synthesizer
// (R15) M and N registers hold synthesizer divider values
// (R16) Slip request shifts frame sync one symbol
// (R17) Host writes slip request back to zero
// (R18) Slip requests ignored unless feedback enabled
// (R19) Demodulator space has six control/monitor sub-groups
// (R20) Sub-group B spans 0F-1B and 46-52
// (R21) Bank select location decoded in every bank
// (R22) Registers reachable by parallel or serial port
// (R23) Strobe bits are single-cycle pulses, never stored
// (R24) Write-only and unused bits read as zero
package ucr_pkg;
  // Register offsets inside bank 0
  localparam logic [7:0] ADDR_UNIV_LO = 8'hF0;
  localparam logic [7:0] ADDR_TEST    = 8'hF1;
  localparam logic [7:0] ADDR_FIFO    = 8'hF3;
  localparam logic [7:0] ADDR_FRAME   = 8'hF4;
  localparam logic [7:0] ADDR_BYPASS  = 8'hF5;
  localparam logic [7:0] ADDR_RX_M    = 8'hF6;
  localparam logic [7:0] ADDR_RX_N    = 8'hF7;
  localparam logic [7:0] ADDR_TX_M    = 8'hF8;
  localparam logic [7:0] ADDR_TX_N    = 8'hF9;
  localparam logic [7:0] ADDR_STROBE  = 8'hFC;
  localparam logic [7:0] ADDR_RETRY   = 8'hFD;
  localparam logic [7:0] ADDR_MODE    = 8'hFE;
  localparam logic [7:0] ADDR_BANK    = 8'hFF;
  // Field positions
  localparam int TEST_BYP_BIT  = 3;
  localparam int FIFO_RST_BIT  = 5;
  localparam int FRAME_BYP_BIT = 5;
  localparam int FB_EN_BIT     = 4;
  localparam int RX_BYP_BIT    = 1;
  localparam int TX_BYP_BIT    = 0;
  localparam int SLIP_BIT      = 7;
  localparam int LD_RX_M_BIT   = 4;
  localparam int LD_RX_N_BIT   = 3;
  localparam int LD_TX_M_BIT   = 2;
  localparam int LD_TX_N_BIT   = 1;
  localparam int START_BIT     = 0;
  localparam int DEMOD_EN_BIT  = 4;
  localparam int CONST_LSB     = 2;
  localparam int ECS_LSB       = 0;
  // Load strobe vector positions on the output port
  localparam int LDV_RX_M = 3;
  localparam int LDV_RX_N = 2;
  localparam int LDV_TX_M = 1;
  localparam int LDV_TX_N = 0;
  // Field codes
  localparam logic [1:0] ECS_ANNEX_A  = 2'h0;
  localparam logic [1:0] ECS_ANNEX_B  = 2'h1;
  localparam logic [1:0] ECS_VENDOR   = 2'h2;
  localparam logic [1:0] CONST_16     = 2'h0;
  localparam logic [1:0] CONST_64     = 2'h1;
  localparam logic [1:0] CONST_256    = 2'h2;
  localparam logic [1:0] BANK_UNIV    = 2'h0;
  // Values after reset
  localparam logic [7:0] RST_RETRY    = 8'h04;
  localparam logic [1:0] RST_FACT_F5  = 2'h2;
  // Sub-group upper bounds: control ranges then monitoring ranges
  localparam logic [7:0] SG_A_RW_HI = 8'h0E;
  localparam logic [7:0] SG_B_RW_HI = 8'h1B;
  localparam logic [7:0] SG_C_RW_HI = 8'h20;
  localparam logic [7:0] SG_D_RW_HI = 8'h24;
  localparam logic [7:0] SG_E_RW_HI = 8'h26;
  localparam logic [7:0] SG_F_RW_HI = 8'h3F;
  localparam logic [7:0] SG_A_RO_HI = 8'h45;
  localparam logic [7:0] SG_B_RO_HI = 8'h52;
  localparam logic [7:0] SG_C_RO_HI = 8'h5B;
  localparam logic [7:0] SG_D_RO_HI = 8'h5F;
  localparam logic [7:0] SG_F_RO_HI = 8'h6A;
  localparam logic [7:0] SG_D2_RO_HI = 8'h9A;
  localparam logic [7:0] SG_E_RO_HI = 8'hB2;
  localparam logic [2:0] SG_A = 3'h0;
  localparam logic [2:0] SG_B = 3'h1;
  localparam logic [2:0] SG_C = 3'h2;
  localparam logic [2:0] SG_D = 3'h3;
  localparam logic [2:0] SG_E = 3'h4;
  localparam logic [2:0] SG_F = 3'h5;
  localparam logic [2:0] SG_NONE = 3'h7;
  // Serial frame: read flag, address, optional data
  localparam logic [4:0] SER_HDR_BITS = 5'h09;
  localparam logic [4:0] SER_WR_BITS  = 5'h11;
  typedef enum logic {ACQ_IDLE, ACQ_RUN} acq_t;
endpackage

// ### host_req_if.sv
// Interface carrying host register requests and read answers
`timescale 1ns/1ps
interface host_req_if;
  logic       req;    // One-cycle request pulse
  logic       wr;     // High for write, low for read
  logic [7:0] addr;   // Register offset
  logic [7:0] wdata;  // Write data
  logic [7:0] rdata;  // Read answer
  logic       rvalid; // Read answer pulse
  modport port (output req, wr, addr, wdata, input rdata, rvalid);
  modport regs (input req, wr, addr, wdata, output rdata, rvalid);
endinterface

// ### host_port.sv
// Parallel and serial microcontroller port front end
`timescale 1ns/1ps
module host_port (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic [7:0] parAddr,
  input  wire logic [7:0] parData,
  input  wire logic       parWrN,
  input  wire logic       parRdN,
  input  wire logic       serClk,
  input  wire logic       serCsN,
  input  wire logic       serDin,
  output logic      [7:0] parRdData,
  output logic            serDout,
  host_req_if.port        bus
);
  import ucr_pkg::*;

  // Pin bits: 0 wrN, 1 rdN, 2 sclk, 3 csN, 4 sdi
  typedef struct packed {
    logic [4:0]  s1, s2, s3, lvl; // Three-stage pin synchroniser
    logic [15:0] p1, p2, p3;      // Parallel address/data synchroniser
    logic        req, wr;
    logic [7:0]  addr, wdata;
    logic [16:0] shift;           // Serial input shifter
    logic [4:0]  cnt;             // Serial bits taken this frame
    logic        rdPar, rdSer;    // Which port waits for an answer
    logic [7:0]  parOut, serOut;
    logic        sdo;
  } hp_t;

  hp_t        q, n;
  logic [4:0] agree, rise, fall;
  logic [16:0] sh;

  // Next state of the whole front end
  always_comb begin
    n = q;
    n.req = 1'b0;
    n.s1 = {serDin, serCsN, serClk, parRdN, parWrN};
    n.s2 = q.s1;
    n.s3 = q.s2;
    n.p1 = {parAddr, parData};
    n.p2 = q.p1;
    n.p3 = q.p2;
    // A level change counts only once stages two and three agree
    agree = ~(q.s2 ^ q.s3);
    n.lvl = (agree & q.s3) | (~agree & q.lvl);
    rise = ~q.lvl & n.lvl;
    fall = q.lvl & ~n.lvl;
    sh = {q.shift[15:0], n.lvl[4]};
    if (fall[0]) begin // see (R22)
      n.req = 1'b1;
      n.wr = 1'b1;
      n.addr = q.p3[15:8];
      n.wdata = q.p3[7:0];
    end else if (fall[1]) begin
      n.req = 1'b1;
      n.wr = 1'b0;
      n.addr = q.p3[15:8];
      n.rdPar = 1'b1;
    end
    // Serial frame, bits taken on rising clock while selected
    if (n.lvl[3]) begin
      n.cnt = '0;
    end else if (rise[2] && !fall[0] && !fall[1]) begin // see (R22)
      n.shift = sh;
      n.cnt = q.cnt + 5'h01;
      if (n.cnt == SER_HDR_BITS && sh[8]) begin
        n.req = 1'b1;
        n.wr = 1'b0;
        n.addr = sh[7:0];
        n.rdSer = 1'b1;
      end else if (n.cnt == SER_WR_BITS && !sh[16]) begin
        n.req = 1'b1;
        n.wr = 1'b1;
        n.addr = sh[15:8];
        n.wdata = sh[7:0];
      end
    end
    // Read data leaves MSB first on falling serial clock
    if (fall[2] && !n.lvl[3]) begin
      n.sdo = q.serOut[7];
      n.serOut = {q.serOut[6:0], 1'b0};
    end
    if (bus.rvalid) begin
      if (q.rdPar) n.parOut = bus.rdata;
      if (q.rdSer) n.serOut = bus.rdata;
      n.rdPar = 1'b0;
      n.rdSer = 1'b0;
    end
  end

  // Strobe, clock and select pins idle high after reset so no false strobe is seen
  always_ff @(posedge clk) begin
    if (rst) begin
      q <= '0;
      q.s1 <= 5'h0F;
      q.s2 <= 5'h0F;
      q.s3 <= 5'h0F;
      q.lvl <= 5'h0F;
    end else begin
      q <= n;
    end
  end

  assign bus.req   = q.req;
  assign bus.wr    = q.wr;
  assign bus.addr  = q.addr;
  assign bus.wdata = q.wdata;
  assign parRdData = q.parOut;
  assign serDout   = q.sdo;
endmodule

// ### ucr_regs.sv
// Universal control registers, acquisition retry engine, bank decode
`timescale 1ns/1ps
module ucr_regs (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic [7:0] parAddr,
  input  wire logic [7:0] parData,
  input  wire logic       parWrN,
  input  wire logic       parRdN,
  input  wire logic       serClk,
  input  wire logic       serCsN,
  input  wire logic       serDin,
  output logic      [7:0] parRdData,
  output logic            serDout,
  output logic            mpegFramingBypass,
  output logic      [1:0] errorCodeSelect,
  output logic            demodTestBypass,
  output logic            rxSynthBypass,
  output logic            txSynthBypass,
  output logic      [7:0] rxSynthM,
  output logic      [7:0] rxSynthN,
  output logic      [7:0] txSynthM,
  output logic      [7:0] txSynthN,
  output logic      [3:0] synthLoad,
  output logic            outputFifoReset,
  output logic            decoderFeedbackEnable,
  output logic            frameSlip,
  output logic            demodEnable,
  output logic      [1:0] constellationSelect,
  input  wire logic       acqAttemptEnd,
  input  wire logic       acqLocked,
  output logic            acqLaunch,
  output logic            acqFail,
  output logic            acqBusy,
  output logic      [7:0] acqTryCount,
  output logic      [1:0] bankSel,
  output logic            extWe,
  output logic            extRe,
  output logic      [7:0] extAddr,
  output logic      [7:0] extWrData,
  output logic      [2:0] subGroup,
  output logic            subMonitor,
  input  wire logic [7:0] extRdData
);
  import ucr_pkg::*;

  // All state of the block in one record
  typedef struct packed {
    acq_t       acq;        // Acquisition engine state
    logic       busy;       // Registered copy of running state
    logic [7:0] tries;      // Attempts in the current round
    logic       testByp;
    logic [2:0] factF1;     // Factory bits, kept for read-back
    logic       frameByp;
    logic       fbEn;
    logic [3:0] factF4;
    logic [1:0] factF5;
    logic       rxByp, txByp;
    logic [7:0] rxM, rxN, txM, txN;             // Stored dividers
    logic [7:0] rxMOut, rxNOut, txMOut, txNOut; // Synthesizer copies
    logic [3:0] load;
    logic       fifoRst, slip;
    logic [7:0] retry;
    logic       demodEn;
    logic [1:0] constSel, ecs, bank;
    logic       launch, fail;
    logic       extWe, extRe;
    logic [7:0] extAddr, extWd;
    logic [2:0] sg;
    logic       mon;
    logic       rdPend, rdExt;
    logic [7:0] rdLocal, rdata;
    logic       rvalid;
  } st_t;

  st_t        q, n;
  logic       isLocal;   // Request lands in this block
  logic       startHit;  // Start bit written this cycle
  logic [7:0] localRd;   // Read-back of the addressed register
  logic [3:0] sgDec;     // {monitor, sub-group} of the address

  host_req_if hb ();

  host_port u_port (
    .clk       (clk),
    .rst       (rst),
    .parAddr   (parAddr),
    .parData   (parData),
    .parWrN    (parWrN),
    .parRdN    (parRdN),
    .serClk    (serClk),
    .serCsN    (serCsN),
    .serDin    (serDin),
    .parRdData (parRdData),
    .serDout   (serDout),
    .bus       (hb.port)
  );

  // Map a demodulator offset to its sub-group and set
  function automatic logic [3:0] subgroup_of(input logic [7:0] a);
    logic [3:0] r;
    r = {1'b0, SG_NONE};
    if (a <= SG_A_RW_HI)       r = {1'b0, SG_A}; // see (R19)
    else if (a <= SG_B_RW_HI)  r = {1'b0, SG_B}; // see (R20)
    else if (a <= SG_C_RW_HI)  r = {1'b0, SG_C};
    else if (a <= SG_D_RW_HI)  r = {1'b0, SG_D};
    else if (a <= SG_E_RW_HI)  r = {1'b0, SG_E};
    else if (a <= SG_F_RW_HI)  r = {1'b0, SG_F};
    else if (a <= SG_A_RO_HI)  r = {1'b1, SG_A};
    else if (a <= SG_B_RO_HI)  r = {1'b1, SG_B}; // see (R20)
    else if (a <= SG_C_RO_HI)  r = {1'b1, SG_C};
    else if (a <= SG_D_RO_HI)  r = {1'b1, SG_D};
    else if (a <= SG_F_RO_HI)  r = {1'b1, SG_F};
    else if (a <= SG_D2_RO_HI) r = {1'b1, SG_D};
    else if (a <= SG_E_RO_HI)  r = {1'b1, SG_E};
    return r;
  endfunction

  // Address decode and read-back mux
  always_comb begin
    // Bank select answers in every bank
    isLocal = (hb.addr == ADDR_BANK) ||
              (q.bank == BANK_UNIV && hb.addr >= ADDR_UNIV_LO); // see (R21)
    sgDec = (q.bank == BANK_UNIV) ? subgroup_of(hb.addr)
                                  : {1'b0, SG_NONE};
    startHit = hb.req && hb.wr && isLocal && hb.addr == ADDR_STROBE &&
               hb.wdata[START_BIT];
    // Write-only and unused bits read zero, so read-modify-write
    // never fires a strobe by accident
    localRd = 8'h00; // see (R24)
    if (hb.addr == ADDR_BANK) begin
      localRd = {6'h00, q.bank};
    end else if (hb.addr == ADDR_TEST) begin
      localRd = {4'h0, q.testByp, q.factF1};
    end else if (hb.addr == ADDR_FRAME) begin
      localRd = {3'h0, q.fbEn, q.factF4};
    end else if (hb.addr == ADDR_BYPASS) begin
      localRd = {4'h0, q.factF5, q.rxByp, q.txByp};
    end else if (hb.addr == ADDR_RX_M) begin
      localRd = q.rxM;
    end else if (hb.addr == ADDR_RX_N) begin
      localRd = q.rxN;
    end else if (hb.addr == ADDR_TX_M) begin
      localRd = q.txM;
    end else if (hb.addr == ADDR_TX_N) begin
      localRd = q.txN;
    end else if (hb.addr == ADDR_RETRY) begin
      localRd = q.retry;
    end else if (hb.addr == ADDR_MODE) begin
      localRd = {3'h0, q.demodEn, q.constSel, q.ecs};
    end
  end

  // Next state: register writes, forwarding, acquisition engine
  always_comb begin
    n = q;
    // Strobes live for one cycle only
    n.load = 4'h0; // see (R23)
    n.fifoRst = 1'b0;
    n.slip = 1'b0;
    n.launch = 1'b0;
    n.fail = 1'b0;
    n.extWe = 1'b0;
    n.extRe = 1'b0;
    n.rdPend = 1'b0;
    n.rvalid = 1'b0;
    if (hb.req && isLocal) begin
      if (!hb.wr) begin
        n.rdPend = 1'b1;
        n.rdExt = 1'b0;
        n.rdLocal = localRd;
      end else if (hb.addr == ADDR_BANK) begin
        n.bank = hb.wdata[1:0]; // see (R21)
      end else if (hb.addr == ADDR_TEST) begin
        n.testByp = hb.wdata[TEST_BYP_BIT]; // see (R4)
        n.factF1 = hb.wdata[2:0];
      end else if (hb.addr == ADDR_FIFO) begin
        n.fifoRst = hb.wdata[FIFO_RST_BIT]; // see (R12)
      end else if (hb.addr == ADDR_FRAME) begin
        n.frameByp = hb.wdata[FRAME_BYP_BIT]; // see (R1)
        n.fbEn = hb.wdata[FB_EN_BIT];
        n.factF4 = hb.wdata[3:0];
      end else if (hb.addr == ADDR_BYPASS) begin
        n.rxByp = hb.wdata[RX_BYP_BIT]; // see (R13)
        n.txByp = hb.wdata[TX_BYP_BIT]; // see (R14)
        n.factF5 = hb.wdata[3:2];
      end else if (hb.addr == ADDR_RX_M) begin
        n.rxM = hb.wdata; // see (R15)
      end else if (hb.addr == ADDR_RX_N) begin
        n.rxN = hb.wdata; // see (R15)
      end else if (hb.addr == ADDR_TX_M) begin
        n.txM = hb.wdata; // see (R15)
      end else if (hb.addr == ADDR_TX_N) begin
        n.txN = hb.wdata; // see (R15)
      end else if (hb.addr == ADDR_STROBE) begin
        // Loads copy stored dividers into the synthesizers
        if (hb.wdata[LD_RX_M_BIT]) n.rxMOut = q.rxM; // see (R5)
        if (hb.wdata[LD_RX_N_BIT]) n.rxNOut = q.rxN; // see (R5)
        if (hb.wdata[LD_TX_M_BIT]) n.txMOut = q.txM; // see (R6)
        if (hb.wdata[LD_TX_N_BIT]) n.txNOut = q.txN; // see (R6)
        n.load = {hb.wdata[LD_RX_M_BIT], hb.wdata[LD_RX_N_BIT],
                  hb.wdata[LD_TX_M_BIT], hb.wdata[LD_TX_N_BIT]};
        // Slip only honoured with decoder feedback enabled
        n.slip = hb.wdata[SLIP_BIT] && q.fbEn; // see (R16) (R18)
      end else if (hb.addr == ADDR_RETRY) begin
        n.retry = hb.wdata;
      end else if (hb.addr == ADDR_MODE) begin
        n.demodEn = hb.wdata[DEMOD_EN_BIT];
        n.constSel = hb.wdata[CONST_LSB +: 2]; // see (R11)
        n.ecs = hb.wdata[ECS_LSB +: 2]; // see (R3)
      end
    end else if (hb.req) begin
      // Everything else goes to the demodulator and other banks
      n.extWe = hb.wr; // see (R19)
      n.extRe = !hb.wr;
      n.extAddr = hb.addr;
      n.extWd = hb.wdata;
      n.sg = sgDec[2:0];
      n.mon = sgDec[3];
      if (!hb.wr) begin
        n.rdPend = 1'b1;
        n.rdExt = 1'b1;
      end
    end
    // External answer must be valid while extRe is high
    if (q.rdPend) begin
      n.rvalid = 1'b1;
      n.rdata = q.rdExt ? extRdData : q.rdLocal;
    end
    // Acquisition engine; start is ignored while disabled
    case (q.acq)
      ACQ_IDLE: begin
        if (startHit && q.demodEn) begin // see (R7)
          n.acq = ACQ_RUN;
          n.tries = 8'h00;
          n.launch = 1'b1;
        end
      end
      ACQ_RUN: begin
        if (!q.demodEn || acqLocked) begin
          n.acq = ACQ_IDLE;
        end else if (startHit) begin
          n.tries = 8'h00;
          n.launch = 1'b1;
        end else if (acqAttemptEnd) begin
          n.launch = 1'b1;
          if (q.tries + 8'h01 >= q.retry) begin // see (R8)
            n.fail = 1'b1;
            n.tries = 8'h00; // see (R9)
          end else begin
            n.tries = q.tries + 8'h01;
          end
        end
      end
      default: n.acq = ACQ_IDLE;
    endcase
    n.busy = (n.acq == ACQ_RUN);
  end

  // State register
  always_ff @(posedge clk) begin
    if (rst) begin
      q <= '0;
      q.acq <= ACQ_IDLE;
      q.retry <= RST_RETRY;
      q.factF5 <= RST_FACT_F5;
    end else begin
      q <= n;
    end
  end

  assign hb.rdata = q.rdata;
  assign hb.rvalid = q.rvalid;
  assign mpegFramingBypass = q.frameByp;
  assign errorCodeSelect = q.ecs;
  assign demodTestBypass = q.testByp;
  assign rxSynthBypass = q.rxByp;
  assign txSynthBypass = q.txByp;
  assign rxSynthM = q.rxMOut;
  assign rxSynthN = q.rxNOut;
  assign txSynthM = q.txMOut;
  assign txSynthN = q.txNOut;
  assign synthLoad = q.load;
  assign outputFifoReset = q.fifoRst;
  assign decoderFeedbackEnable = q.fbEn;
  assign frameSlip = q.slip;
  assign demodEnable = q.demodEn;
  assign constellationSelect = q.constSel;
  assign acqLaunch = q.launch;
  assign acqFail = q.fail;
  assign acqBusy = q.busy;
  assign acqTryCount = q.tries;
  assign bankSel = q.bank;
  assign extWe = q.extWe;
  assign extRe = q.extRe;
  assign extAddr = q.extAddr;
  assign extWrData = q.extWd;
  assign subGroup = q.sg;
  assign subMonitor = q.mon;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // Start while enabled and idle opens a fresh round
  property p_start_launch;
    startHit && q.demodEn && q.acq == ACQ_IDLE
      |=> acqLaunch && acqBusy && acqTryCount == 8'h00;
  endproperty
  a_start_launch: assert property (p_start_launch) // see (R7)
    else $error("start did not launch acquisition");

  // Reaching the limit fails the round
  property p_fail_at_limit;
    q.acq == ACQ_RUN && q.demodEn && !acqLocked && !startHit &&
      acqAttemptEnd && (q.tries + 8'h01 >= q.retry) |=> acqFail;
  endproperty
  a_fail_at_limit: assert property (p_fail_at_limit) // see (R8)
    else $error("no failure at retry limit");

  // Failure comes with a fresh attempt from zero
  property p_fail_restart;
    acqFail |-> acqLaunch && acqTryCount == 8'h00 && acqBusy;
  endproperty
  a_fail_restart: assert property (p_fail_restart) // see (R9)
    else $error("failure without restart");

  // Slip pulse only with feedback enabled
  property p_slip_gate;
    frameSlip |-> $past(decoderFeedbackEnable);
  endproperty
  a_slip_gate: assert property (p_slip_gate) // see (R18)
    else $error("slip while feedback disabled");

  // FIFO reset is a lone one-cycle pulse
  property p_fifo_pulse;
    outputFifoReset |=> !outputFifoReset;
  endproperty
  a_fifo_pulse: assert property (p_fifo_pulse) // see (R23)
    else $error("FIFO reset held longer than one cycle");

  // A receive M load presents the stored divider
  property p_rx_m_load;
    synthLoad[LDV_RX_M] |-> rxSynthM == q.rxM;
  endproperty
  a_rx_m_load: assert property (p_rx_m_load) // see (R5)
    else $error("receive M load value mismatch");

  // Read of the strobe location answers zero two cycles later
  sequence s_read_strobe;
    hb.req && !hb.wr && isLocal && hb.addr == ADDR_STROBE;
  endsequence
  sequence s_zero_answer;
    ##2 hb.rvalid && hb.rdata == 8'h00;
  endsequence
  property p_strobe_reads_zero;
    s_read_strobe |-> s_zero_answer;
  endproperty
  a_strobe_reads_zero: assert property (p_strobe_reads_zero) // see (R24)
    else $error("strobe location read not zero");

  // Sub-group B control range is forwarded as control
  property p_subgroup_b;
    hb.req && q.bank == BANK_UNIV && hb.addr >= 8'h0F &&
      hb.addr <= SG_B_RW_HI
      |=> (extWe || extRe) && subGroup == SG_B && !subMonitor;
  endproperty
  a_subgroup_b: assert property (p_subgroup_b) // see (R20)
    else $error("sub-group B decode wrong");
endmodule

// ### host_mcu_model.sv
// Host microcontroller model on the parallel and serial register ports
`timescale 1ns/1ps
module host_mcu_model (
  input  wire logic       clk,
  input  wire logic [7:0] parRdData,
  input  wire logic       serDout,
  output logic      [7:0] parAddr,
  output logic      [7:0] parData,
  output logic            parWrN,
  output logic            parRdN,
  output logic            serClk,
  output logic            serCsN,
  output logic            serDin
);
  // Idle pins: strobes, select and serial clock high
  initial begin
    parAddr = 8'h00;
    parData = 8'h00;
    parWrN = 1'b1;
    parRdN = 1'b1;
    serClk = 1'b1;
    serCsN = 1'b1;
    serDin = 1'b0;
  end
  // One access; callers keep factory fields at fixed values
  // Bank select reached like any register
  task automatic acc(input logic w, input logic [7:0] a, d,
                     output logic [7:0] q);
    @(negedge clk);
    parAddr = a;
    parData = d;
    // Pins pass three sync flops, so settle first
    repeat (5) @(negedge clk);
    if (w) begin
      parWrN = 1'b0;
    end else begin
      parRdN = 1'b0;
    end
    repeat (8) @(negedge clk);
    q = parRdData;
    parWrN = 1'b1;
    parRdN = 1'b1;
    // Released bus no longer shows the old value
    parAddr = ~a;
    parData = ~d;
    repeat (8) @(negedge clk);
  endtask
  // Serial frame MSB first, always 17 clocks; read bits come back on
  // the last eight falling edges, so a read frame never looks like a write
  task automatic ser(input logic r, input logic [7:0] a, d,
                     output logic [7:0] q);
    logic [16:0] f;
    f = {r, a, d};
    q = 8'h00;
    serCsN = 1'b0;
    for (int i = 16; i >= 0; i--) begin
      serClk = 1'b0;
      serDin = f[i];
      repeat (8) @(negedge clk);
      if (r && i < 8) q[i] = serDout;
      serClk = 1'b1;
      repeat (8) @(negedge clk);
    end
    serCsN = 1'b1;
    serDin = ~serDin;
    repeat (8) @(negedge clk);
  endtask
endmodule

// ### rx_universal_control_regs_tb_top.sv
// Self-checking bench for the universal control registers
`timescale 1ns/1ps
module rx_universal_control_regs_tb_top;
  import ucr_pkg::*;
  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic       acqAttemptEnd = 1'b0;
  logic       acqLocked = 1'b0;
  logic [7:0] parAddr, parData, parRdData, q;
  logic       parWrN, parRdN;
  logic [7:0] rxM, rxN, txM, txN, tc, ea, ewd;
  logic [1:0] ecs, cs, bank;
  logic [3:0] ld;
  logic [2:0] sg;
  logic       mfb, tby, rxb, txb, ffr, fbe, slp, den;
  logic       lau, fl, bsy, mon, ewe, ere;
  logic       serClk, serCsN, serDin, serDout;
  int         cnt[10];
  int         fails = 0;
  int         num_checks = 0;
  always #5 clk = ~clk;
  host_mcu_model host (.clk(clk), .parRdData(parRdData),
    .parAddr(parAddr), .parData(parData), .parWrN(parWrN), .parRdN(parRdN),
    .serDout(serDout), .serClk(serClk), .serCsN(serCsN), .serDin(serDin));
  // Model drives both host ports; external read data fixed
  ucr_regs dut (.clk(clk), .rst(rst), .parAddr(parAddr),
    .parData(parData), .parWrN(parWrN), .parRdN(parRdN), .serClk(serClk),
    .serCsN(serCsN), .serDin(serDin), .parRdData(parRdData),
    .serDout(serDout),
    .mpegFramingBypass(mfb), .errorCodeSelect(ecs), .demodTestBypass(tby),
    .rxSynthBypass(rxb), .txSynthBypass(txb), .rxSynthM(rxM),
    .rxSynthN(rxN), .txSynthM(txM), .txSynthN(txN), .synthLoad(ld),
    .outputFifoReset(ffr), .decoderFeedbackEnable(fbe), .frameSlip(slp),
    .demodEnable(den), .constellationSelect(cs),
    .acqAttemptEnd(acqAttemptEnd), .acqLocked(acqLocked), .acqLaunch(lau),
    .acqFail(fl), .acqBusy(bsy), .acqTryCount(tc), .bankSel(bank),
    .extWe(ewe), .extRe(ere), .extAddr(ea), .extWrData(ewd), .subGroup(sg),
    .subMonitor(mon), .extRdData(8'h5A));
  // Pulse counters: loads, FIFO reset, slip, launch, fail, forwarding
  always @(posedge clk) begin
    if (!rst) begin
      for (int i = 0; i < 10; i++) begin
        cnt[i] += int'({ere, ewe, fl, lau, slp, ffr, ld} >> i & 10'h001);
      end
    end
  end
  task automatic chk(input logic [15:0] g, e);
    num_checks++;
    if (g !== e) begin
      fails++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, d);
    host.acc(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a, e);
    host.acc(1'b0, a, 8'h00, q);
    chk(q, e);
  endtask
  // One failed attempt reported by the demodulator
  task automatic miss();
    @(negedge clk);
    acqAttemptEnd = 1'b1;
    @(negedge clk);
    acqAttemptEnd = 1'b0;
    repeat (3) @(negedge clk);
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // Hang guard
  initial begin
    #500us;
    fails++;
    complete_run();
  end
  initial begin
    repeat (12) @(negedge clk);
    rst = 1'b0;
    repeat (4) @(negedge clk);
    rd(ADDR_RETRY, 8'h04);
    rd(ADDR_BYPASS, 8'h08);
    rd(ADDR_STROBE, 8'h00);
    // Every pair of the defined codes 0 to 2 of the mode register
    for (int c = 0; c < 3; c++) begin
      for (int e = 0; e < 3; e++) begin
        wr(ADDR_MODE, 8'(c * 4 + e));
        chk({4'h0, cs, ecs}, 8'(c * 4 + e));
      end
    end
    wr(ADDR_TEST, 8'h08);
    chk(tby, 8'h01);
    wr(ADDR_BYPASS, 8'h0B);
    chk({rxb, txb}, 8'h03);
    rd(ADDR_BYPASS, 8'h0B);
    wr(ADDR_FRAME, 8'h20);
    chk(mfb, 8'h01);
    rd(ADDR_FRAME, 8'h00);
    // Divider values wait for their load strobes
    wr(ADDR_RX_M, 8'h11);
    wr(ADDR_RX_N, 8'h22);
    wr(ADDR_TX_M, 8'h33);
    wr(ADDR_TX_N, 8'h44);
    chk(rxM, 8'h00);
    rd(ADDR_RX_M, 8'h11);
    wr(ADDR_STROBE, 8'h10);
    chk(rxM, 8'h11);
    chk(rxN, 8'h00);
    wr(ADDR_STROBE, 8'h0E);
    chk({rxN, txM}, {8'h22, 8'h33});
    chk(txN, 8'h44);
    chk(8'(cnt[0] + cnt[1] + cnt[2] + cnt[3]), 8'h04);
    wr(ADDR_FIFO, 8'h20);
    chk(8'(cnt[4]), 8'h01);
    // Slip ignored until feedback enabled, then written back to zero
    wr(ADDR_STROBE, 8'h80);
    chk(8'(cnt[5]), 8'h00);
    wr(ADDR_FRAME, 8'h10);
    chk(fbe, 8'h01);
    wr(ADDR_STROBE, 8'h80);
    wr(ADDR_STROBE, 8'h00);
    chk(8'(cnt[5]), 8'h01);
    // Start refused while demodulator disabled
    wr(ADDR_MODE, 8'h00);
    wr(ADDR_STROBE, 8'h01);
    chk(8'(cnt[6]), 8'h00);
    wr(ADDR_RETRY, 8'h02);
    wr(ADDR_MODE, 8'h10);
    chk(den, 8'h01);
    wr(ADDR_STROBE, 8'h01);
    chk({bsy, tc}, 9'h100);
    miss();
    chk(tc, 8'h01);
    miss();
    chk(8'(cnt[7]), 8'h01);
    chk({bsy, tc}, 9'h100);
    chk(8'(cnt[6]), 8'h03);
    acqLocked = 1'b1;
    repeat (3) @(negedge clk);
    chk(bsy, 8'h00);
    // Serial port reaches the same registers as the parallel one
    host.ser(1'b0, ADDR_RETRY, 8'h3C, q);
    host.ser(1'b1, ADDR_RETRY, 8'h00, q);
    chk(q, 8'h3C);
    rd(ADDR_RETRY, 8'h3C);
    // Demodulator space forwarded and classified
    wr(8'h20, 8'h77);
    chk({ea, ewd}, {8'h20, 8'h77});
    chk({mon, sg, 8'(cnt[8])}, {1'b0, SG_C, 8'h01});
    rd(8'h10, 8'h5A);
    chk({mon, sg}, {1'b0, SG_B});
    rd(8'h46, 8'h5A);
    chk({mon, sg}, {1'b1, SG_B});
    wr(ADDR_BANK, 8'h01);
    rd(ADDR_TEST, 8'h5A);
    rd(ADDR_BANK, 8'h01);
    chk(bank, 8'h01);
    chk(8'(cnt[9]), 8'h03);
    complete_run();
  end
endmodule
